//--- rtl/embs_cfg.svh
// Constants for the external memory bus sequencer
`ifndef EMBS_CFG_SVH
`define EMBS_CFG_SVH
`define EMBS_ADDR_W 32
`define EMBS_DATA_W 32
`define EMBS_PAR_W 4
`define EMBS_LANES 4
`define EMBS_MAX_BLOCK 16
`define EMBS_BLK_LO 2
`define EMBS_BLK_HI 5
`define EMBS_BYTES_PER_WORD 3'd4
`endif

//--- rtl/embs_pkg.sv
// Types for the external memory bus sequencer
package embs_pkg;
    typedef enum logic [1:0] {
        EMBS_OP_READ = 2'b00,
        EMBS_OP_BLOCK = 2'b01,
        EMBS_OP_WRITE = 2'b10
    } embs_op_t;
    typedef enum logic [5:0] {
        EMBS_IDLE = 6'b00_0001,
        EMBS_ST1 = 6'b00_0010,
        EMBS_ST2 = 6'b00_0100,
        EMBS_WAIT = 6'b00_1000,
        EMBS_ST3 = 6'b01_0000,
        EMBS_ST4 = 6'b10_0000
    } embs_state_t;
endpackage

//--- rtl/embs_sample.sv
// Half-cycle sampler for the memory-side status inputs
`timescale 1ns/1ps
`default_nettype none
module embs_sample (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // Raw status from the memory system, active low
    input wire logic mem_ready_n,
    input wire logic bus_error_n,
    input wire logic parity_enable_n,
    input wire logic cacheable_n,
    input wire logic block_ack_n,
    input wire logic byte_wide_n,
    // Values caught at the falling edge, active high
    output logic ready,
    output logic berr,
    output logic par_en,
    output logic cach,
    output logic blk_ack,
    output logic bwide
);
    typedef struct packed {
        logic ready;
        logic berr;
        logic par_en;
        logic cach;
        logic blk_ack;
        logic bwide;
    } embs_smp_t;
    embs_smp_t s;
    embs_smp_t next_s;
    // Inversion to active high before the falling-edge capture
    always_comb
    begin
        next_s.ready = ~mem_ready_n;
        next_s.berr = ~bus_error_n;
        next_s.par_en = ~parity_enable_n;
        next_s.cach = ~cacheable_n;
        next_s.blk_ack = ~block_ack_n;
        next_s.bwide = ~byte_wide_n;
    end
    // Falling edge catch, so the rising-edge sequencer sees mid-cycle values
    always_ff @(negedge core_clk)
    begin
        if (!rst_n)
            s <= '0;
        else
            s <= next_s;
    end
    assign ready = s.ready;
    assign berr = s.berr;
    assign par_en = s.par_en;
    assign cach = s.cach;
    assign blk_ack = s.blk_ack;
    assign bwide = s.bwide;
endmodule
`default_nettype wire

//--- rtl/embs_seq.sv
// External memory bus sequencer: word read, block fetch, write, byte gathering
`timescale 1ns/1ps
`default_nettype none
`include "embs_cfg.svh"
// How it works
// - Opening edge drives address, start strobe, and block request when wanted
// - Second read state asserts address-valid and read strobes
// - Falling-edge sample; ready or error ends wait, else wait again
// - Final read state captures data and parity, restores address, drops strobes
// - Block fetch moves two to sixteen words in one transaction
// - Block acknowledge zeroes address bits five to two modulo block size
// - No address advance when ready was not sampled asserted
// - Block transfers capture data, bump address, stop at count one or error
// - Every block-fetched word goes to cache regardless of cacheable
// - Write start drives read/write low and keeps read strobe off
// - Third write state drives data, parity, byte strobes, drops start strobe
// - Write waits on falling-edge sample until ready or error
// - Final write state ends releasing address-valid, byte strobes, data, parity
// - Byte-wide acknowledge on first read sample starts byte gathering
// - Byte read repeats per byte, address plus one, early stop on error
// - Sampled bus error ends transaction and raises bus error exception
module embs_seq #(
    parameter int MAX_BLOCK = `EMBS_MAX_BLOCK
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // Processor request side
    input wire logic req_valid,
    input wire embs_pkg::embs_op_t req_op,
    input wire logic [`EMBS_ADDR_W-1:0] req_addr,
    input wire logic [4:0] req_block_words,
    input wire logic [`EMBS_DATA_W-1:0] req_wdata,
    input wire logic [`EMBS_PAR_W-1:0] req_wpar,
    input wire logic [`EMBS_LANES-1:0] req_byte_en,
    input wire logic [`EMBS_ADDR_W-1:0] cur_inst_addr,
    output logic req_ready,
    // Processor answer side
    output logic rsp_valid,
    output logic [`EMBS_DATA_W-1:0] rsp_data,
    output logic [`EMBS_PAR_W-1:0] rsp_par,
    output logic rsp_par_en,
    output logic rsp_cache_fill,
    output logic rsp_done,
    output logic bus_error_exc,
    // Memory bus outputs
    output logic [`EMBS_ADDR_W-1:0] addr_out_bus,
    output logic xact_start_n,
    output logic block_req_out,
    output logic addr_valid_n,
    output logic read_strobe_n,
    output logic read_not_write,
    output logic [`EMBS_DATA_W-1:0] data_out_bus,
    output logic [`EMBS_PAR_W-1:0] data_parity_out,
    output logic [`EMBS_LANES-1:0] byte_write_n,
    // Memory bus inputs
    input wire logic [`EMBS_DATA_W-1:0] data_in_bus,
    input wire logic [`EMBS_PAR_W-1:0] data_parity_in,
    input wire logic mem_ready_n,
    input wire logic parity_enable_n,
    input wire logic bus_error_n,
    input wire logic cacheable_n,
    input wire logic block_ack_n,
    input wire logic byte_wide_n
);
    import embs_pkg::*;

    typedef struct packed {
        embs_state_t st;
        embs_op_t op;
        logic blk, gather;
        logic [4:0] left;
        logic [2:0] bytes_left;
        logic [`EMBS_DATA_W-1:0] wdata;
        logic [`EMBS_PAR_W-1:0] wpar;
        logic [`EMBS_LANES-1:0] ben;
        logic req_ready, rsp_valid;
        logic [`EMBS_DATA_W-1:0] rsp_data;
        logic [`EMBS_PAR_W-1:0] rsp_par;
        logic rsp_par_en, rsp_cache_fill, rsp_done, bus_error_exc;
        logic [`EMBS_ADDR_W-1:0] addr;
        logic xs_n, breq, av_n, rd_n, rnw;
        logic [`EMBS_DATA_W-1:0] dout;
        logic [`EMBS_PAR_W-1:0] pout;
        logic [`EMBS_LANES-1:0] wr_n;
    } embs_seq_t;

    embs_seq_t r, next_r;
    logic s_ready, s_berr, s_par_en, s_cach, s_blk_ack, s_bwide;

    // Status inputs caught on the falling edge of the clock
    embs_sample embs_sample_inst (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .mem_ready_n(mem_ready_n),
        .bus_error_n(bus_error_n),
        .parity_enable_n(parity_enable_n),
        .cacheable_n(cacheable_n),
        .block_ack_n(block_ack_n),
        .byte_wide_n(byte_wide_n),
        .ready(s_ready),
        .berr(s_berr),
        .par_en(s_par_en),
        .cach(s_cach),
        .blk_ack(s_blk_ack),
        .bwide(s_bwide)
    );

    // Block-aligned address: clear word bits inside the block span
    function automatic logic [`EMBS_ADDR_W-1:0] blk_align(
        input logic [`EMBS_ADDR_W-1:0] a,
        input logic [4:0] words
    );
        logic [3:0] mask;
        mask = 4'(words - 5'd1);
        blk_align = a;
        blk_align[`EMBS_BLK_HI:`EMBS_BLK_LO] = a[`EMBS_BLK_HI:`EMBS_BLK_LO] & ~mask;
    endfunction

    // Bounded block length, two words at the least
    function automatic logic [4:0] blk_len(input logic [4:0] w);
        if (w < 5'd2)
            blk_len = 5'd2;
        else if (w > 5'(MAX_BLOCK))
            blk_len = 5'(MAX_BLOCK);
        else
            blk_len = w;
    endfunction

    // Sequencer next state
    always_comb
    begin
        next_r = r;
        next_r.rsp_valid = 1'b0;
        next_r.rsp_done = 1'b0;
        next_r.bus_error_exc = 1'b0;
        case (r.st)
            EMBS_IDLE:
            begin
                next_r.req_ready = 1'b1;
                if (req_valid && r.req_ready)
                begin
                    next_r.req_ready = 1'b0;
                    next_r.op = req_op;
                    next_r.blk = (req_op == EMBS_OP_BLOCK);
                    next_r.gather = 1'b0;
                    next_r.left = blk_len(req_block_words);
                    next_r.bytes_left = `EMBS_BYTES_PER_WORD;
                    next_r.wdata = req_wdata;
                    next_r.wpar = req_wpar;
                    next_r.ben = req_byte_en;
                    next_r.addr = req_addr;
                    next_r.xs_n = 1'b0;
                    next_r.breq = (req_op == EMBS_OP_BLOCK);
                    next_r.rnw = (req_op != EMBS_OP_WRITE);
                    next_r.rd_n = 1'b1;
                    next_r.st = EMBS_ST1;
                end
            end
            EMBS_ST1:
            begin
                next_r.av_n = 1'b0;
                if (r.op != EMBS_OP_WRITE)
                    next_r.rd_n = 1'b0;
                next_r.st = EMBS_ST2;
            end
            EMBS_ST2:
            begin
                if (r.op == EMBS_OP_WRITE)
                begin
                    next_r.dout = r.wdata;
                    next_r.pout = r.wpar;
                    next_r.wr_n = ~r.ben;
                    next_r.xs_n = 1'b1;
                end
                next_r.st = EMBS_WAIT;
            end
            EMBS_WAIT:
            begin
                next_r.xs_n = 1'b1;
                // First sample decides block fetch or byte gathering
                if (r.op != EMBS_OP_WRITE && !r.gather && s_blk_ack && !r.blk)
                    next_r.blk = 1'b1;
                if (r.op != EMBS_OP_WRITE && s_blk_ack)
                    next_r.addr = blk_align(r.addr, r.left);
                if (r.op == EMBS_OP_READ && s_bwide && !r.gather && !s_blk_ack)
                    next_r.gather = 1'b1;
                if (s_ready || s_berr)
                    next_r.st = (r.blk || s_blk_ack) ? EMBS_ST3 : EMBS_ST4;
            end
            EMBS_ST3:
            begin
                // Block transfer state; ready sampled again each pass
                if (s_berr)
                    next_r.st = EMBS_ST4;
                else if (s_ready)
                    next_r.st = EMBS_ST4;
            end
            EMBS_ST4:
            begin
                if (r.op == EMBS_OP_WRITE)
                begin
                    // Release address-valid, byte strobes, data, parity and read/write at the end of the final state; the address is kept
                    next_r.av_n = 1'b1;
                    next_r.wr_n = '1;
                    next_r.dout = '0;
                    next_r.pout = '0;
                    next_r.rnw = 1'b1;
                    next_r.bus_error_exc = s_berr;
                    next_r.rsp_done = 1'b1;
                    next_r.st = EMBS_IDLE;
                end
                else
                begin
                    next_r.rsp_valid = ~s_berr;
                    next_r.rsp_data = data_in_bus;
                    next_r.rsp_par = data_parity_in;
                    next_r.rsp_par_en = s_par_en;
                    next_r.rsp_cache_fill = r.blk | s_cach;
                    if (s_berr)
                    begin
                        // Error ends this and any remaining transfers
                        next_r.bus_error_exc = 1'b1;
                        next_r.rsp_done = 1'b1;
                        next_r.addr = cur_inst_addr;
                        next_r.av_n = 1'b1;
                        next_r.rd_n = 1'b1;
                        next_r.breq = 1'b0;
                        next_r.st = EMBS_IDLE;
                    end
                    else if (r.blk && r.left > 5'd1)
                    begin
                        next_r.left = r.left - 5'd1;
                        next_r.addr = r.addr + 32'h0000_0004;
                        next_r.st = EMBS_ST3;
                    end
                    else if (r.gather && r.bytes_left > 3'd1)
                    begin
                        // Next single-byte transaction at the following byte
                        next_r.bytes_left = r.bytes_left - 3'd1;
                        next_r.addr = r.addr + 32'h0000_0001;
                        next_r.xs_n = 1'b0;
                        next_r.av_n = 1'b1;
                        next_r.rd_n = 1'b1;
                        next_r.st = EMBS_ST1;
                    end
                    else
                    begin
                        next_r.addr = cur_inst_addr;
                        next_r.av_n = 1'b1;
                        next_r.rd_n = 1'b1;
                        next_r.breq = 1'b0;
                        next_r.rsp_done = 1'b1;
                        next_r.st = EMBS_IDLE;
                    end
                end
            end
            default:
                next_r.st = EMBS_IDLE;
        endcase
    end

    // State register with synchronous reset to the idle, strobes-off state
    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            r <= '0;
            r.st <= EMBS_IDLE;
            r.xs_n <= 1'b1;
            r.av_n <= 1'b1;
            r.rd_n <= 1'b1;
            r.rnw <= 1'b1;
            r.wr_n <= '1;
        end
        else
            r <= next_r;
    end

    assign req_ready = r.req_ready;
    assign rsp_valid = r.rsp_valid;
    assign rsp_data = r.rsp_data;
    assign rsp_par = r.rsp_par;
    assign rsp_par_en = r.rsp_par_en;
    assign rsp_cache_fill = r.rsp_cache_fill;
    assign rsp_done = r.rsp_done;
    assign bus_error_exc = r.bus_error_exc;
    assign addr_out_bus = r.addr;
    assign xact_start_n = r.xs_n;
    assign block_req_out = r.breq;
    assign addr_valid_n = r.av_n;
    assign read_strobe_n = r.rd_n;
    assign read_not_write = r.rnw;
    assign data_out_bus = r.dout;
    assign data_parity_out = r.pout;
    assign byte_write_n = r.wr_n;

    // Start strobe follows an accepted request by one edge
    a_start_strobe: assert property (@(posedge core_clk) disable iff (!rst_n)
        (r.st == EMBS_IDLE && req_valid && r.req_ready) |=> !xact_start_n)
        else $error("start strobe not asserted");
    // Read strobes low one edge after the second read state
    a_read_strobes: assert property (@(posedge core_clk) disable iff (!rst_n)
        (r.st == EMBS_ST1 && r.op != EMBS_OP_WRITE) |=> (!addr_valid_n && !read_strobe_n))
        else $error("read strobes missing");
    // Wait only ends on ready or error
    a_wait_hold: assert property (@(posedge core_clk) disable iff (!rst_n)
        (r.st == EMBS_WAIT && !s_ready && !s_berr) |=> r.st == EMBS_WAIT)
        else $error("wait left early");
    // Write never drives read strobe
    a_write_rd: assert property (@(posedge core_clk) disable iff (!rst_n)
        (!read_not_write) |-> read_strobe_n)
        else $error("read strobe in write");
    // Write byte strobes appear and start strobe drops in the third state
    a_write_drive: assert property (@(posedge core_clk) disable iff (!rst_n)
        (r.st == EMBS_ST2 && r.op == EMBS_OP_WRITE) |=> (byte_write_n == ~r.ben && xact_start_n))
        else $error("write strobes wrong");
    // Write release after final state
    a_write_end: assert property (@(posedge core_clk) disable iff (!rst_n)
        (r.st == EMBS_ST4 && r.op == EMBS_OP_WRITE) |=> (addr_valid_n && byte_write_n == '1))
        else $error("write not released");
    // Error raises the exception pulse
    a_err_exc: assert property (@(posedge core_clk) disable iff (!rst_n)
        (r.st == EMBS_ST4 && s_berr) |=> (bus_error_exc && r.st == EMBS_IDLE))
        else $error("bus error not taken");
    // Block words always cached
    a_blk_cache: assert property (@(posedge core_clk) disable iff (!rst_n)
        (rsp_valid && $past(r.blk)) |-> rsp_cache_fill)
        else $error("block word not cached");
endmodule
`default_nettype wire

//--- testbench/embs_mem_model.sv
// Behavioural external memory system facing the bus sequencer
`timescale 1ns/1ps
`default_nettype none
module embs_mem_model (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // Behaviour controls from the bench
    input wire logic [3:0] lat,
    input wire logic slow,
    input wire logic byte_mode,
    input wire logic par_on,
    input wire logic err_arm,
    // Bus from the sequencer
    input wire logic [31:0] addr_out_bus,
    input wire logic xact_start_n,
    input wire logic block_req_out,
    input wire logic addr_valid_n,
    input wire logic read_strobe_n,
    input wire logic read_not_write,
    input wire logic [31:0] data_out_bus,
    input wire logic [3:0] data_parity_out,
    input wire logic [3:0] byte_write_n,
    // Answers to the sequencer
    output logic [31:0] data_in_bus,
    output logic [3:0] data_parity_in,
    output logic mem_ready_n,
    output logic parity_enable_n,
    output logic bus_error_n,
    output logic cacheable_n,
    output logic block_ack_n,
    output logic byte_wide_n,
    // Last accepted write
    output logic [31:0] wr_data,
    output logic [3:0] wr_par,
    output logic [3:0] wr_be
);
    int cnt;
    logic blk, err_on, err_hold, rbit, go, err_now;
    logic [31:0] junk;
    // Ready only after lat cycles of address-valid; random gaps when slow
    assign go = !addr_valid_n && cnt >= lat && (!slow || rbit);
    assign err_now = err_on && !addr_valid_n && cnt >= lat;
    assign mem_ready_n = !(go && !err_on);
    // Error held one cycle past address-valid release
    assign bus_error_n = !(err_now || err_hold);
    assign block_ack_n = !(blk && !addr_valid_n);
    assign cacheable_n = !(blk && !addr_valid_n);
    assign byte_wide_n = !(byte_mode && !addr_valid_n);
    assign parity_enable_n = !par_on;
    // Drive data only under the read strobe, else a changing pattern
    assign data_in_bus = !read_strobe_n ? addr_out_bus ^ 32'h5a5a_5a5a : junk;
    assign data_parity_in = !read_strobe_n ? addr_out_bus[3:0] ^ addr_out_bus[11:8] : junk[3:0];
    // Transaction tracking and write capture
    always_ff @(posedge core_clk)
    begin
        junk <= ~junk;
        rbit <= 1'($urandom);
        err_hold <= err_now;
        cnt <= addr_valid_n ? 0 : cnt + 1;
        if (!rst_n)
        begin
            junk <= 32'h3c3c_a5a5;
            blk <= 1'b0;
            err_on <= 1'b0;
            err_hold <= 1'b0;
            wr_be <= 4'h0;
        end
        else if (!xact_start_n && addr_valid_n)
        begin
            blk <= block_req_out;
            err_on <= err_arm;
        end
        if (!addr_valid_n && !read_not_write && !mem_ready_n && byte_write_n != 4'hf)
        begin
            wr_data <= data_out_bus;
            wr_par <= data_parity_out;
            wr_be <= ~byte_write_n;
        end
    end
endmodule
`default_nettype wire

//--- testbench/external_memory_bus_sequencer_test.sv
// Self-checking bench for the external memory bus sequencer
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) begin n_tests++; if ((got) !== (exp)) begin err_total++; \
    $display("ERROR t=%0t got %h exp %h", $time, got, exp); end end
module external_memory_bus_sequencer_test;
    import embs_pkg::*;
    // Design and partner signals
    logic core_clk, rst_n, req_valid, req_ready, rsp_valid, rsp_par_en, rsp_cache_fill, rsp_done;
    logic bus_error_exc, xact_start_n, block_req_out, addr_valid_n, read_strobe_n, read_not_write;
    logic mem_ready_n, parity_enable_n, bus_error_n, cacheable_n, block_ack_n, byte_wide_n;
    logic slow, byte_mode, par_on, err_arm, exp_breq, exp_rnw;
    embs_op_t req_op;
    embs_op_t ops[4] = '{EMBS_OP_READ, EMBS_OP_BLOCK, EMBS_OP_WRITE, EMBS_OP_READ};
    logic [31:0] req_addr, req_wdata, cur_inst_addr, rsp_data, addr_out_bus, data_out_bus, data_in_bus;
    logic [31:0] wr_data, exp_start;
    logic [4:0] req_block_words;
    logic [3:0] req_wpar, req_byte_en, rsp_par, data_parity_out, byte_write_n, data_parity_in, wr_par, wr_be, lat;
    int err_total, n_tests;
    embs_seq #(.MAX_BLOCK(16)) embs_seq_inst (.core_clk, .rst_n, .req_valid, .req_op, .req_addr, .req_block_words,
        .req_wdata, .req_wpar, .req_byte_en, .cur_inst_addr, .req_ready, .rsp_valid, .rsp_data, .rsp_par,
        .rsp_par_en, .rsp_cache_fill, .rsp_done, .bus_error_exc, .addr_out_bus, .xact_start_n, .block_req_out,
        .addr_valid_n, .read_strobe_n, .read_not_write, .data_out_bus, .data_parity_out, .byte_write_n,
        .data_in_bus, .data_parity_in, .mem_ready_n, .parity_enable_n, .bus_error_n, .cacheable_n,
        .block_ack_n, .byte_wide_n);
    embs_mem_model embs_mem_model_inst (.core_clk, .rst_n, .lat, .slow, .byte_mode, .par_on, .err_arm,
        .addr_out_bus, .xact_start_n, .block_req_out, .addr_valid_n, .read_strobe_n, .read_not_write,
        .data_out_bus, .data_parity_out, .byte_write_n, .data_in_bus, .data_parity_in, .mem_ready_n,
        .parity_enable_n, .bus_error_n, .cacheable_n, .block_ack_n, .byte_wide_n, .wr_data, .wr_par, .wr_be);
    // Clock at 40 MHz
    initial
    begin
        core_clk = 1'b0;
        forever
            #12.5 core_clk = ~core_clk;
    end
    // Bus watch on settled values at each falling edge
    always @(negedge core_clk)
    begin
        if (rst_n)
            `CHK(read_strobe_n | read_not_write, 1'b1)
        if (rst_n && !xact_start_n && addr_valid_n)
        begin
            `CHK({addr_out_bus, block_req_out, read_not_write}, {exp_start, exp_breq, exp_rnw})
            exp_start = exp_start + 32'd1;
        end
        if (rst_n && !addr_valid_n && read_not_write)
            `CHK(read_strobe_n, 1'b0)
        if (rst_n && !addr_valid_n && !read_not_write && xact_start_n)
            `CHK({byte_write_n, data_out_bus, data_parity_out}, {~req_byte_en, req_wdata, req_wpar})
    end
    // Verdict and end of run
    task automatic finish_test();
        if (err_total == 0 && n_tests > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    // One processor request, then every answer checked against the memory contents
    task automatic op_run(input embs_op_t op, input logic [31:0] a, input logic [4:0] n, input logic [3:0] l,
        input logic s, input logic byt, input logic e);
        int i;
        int k;
        logic exc;
        logic [31:0] ea;
        k = 0;
        exc = 1'b0;
        ea = (op == EMBS_OP_BLOCK) ? a & ~((32'(n) << 2) - 32'd1) : a;
        exp_start = a;
        exp_breq = (op == EMBS_OP_BLOCK);
        exp_rnw = (op != EMBS_OP_WRITE);
        @(posedge core_clk);
        req_valid <= 1'b1;
        req_op <= op;
        req_addr <= a;
        req_block_words <= n;
        req_wdata <= $urandom;
        req_wpar <= 4'($urandom);
        req_byte_en <= 4'($urandom_range(15, 1));
        cur_inst_addr <= $urandom;
        lat <= l;
        slow <= s;
        byte_mode <= byt;
        err_arm <= e;
        par_on <= 1'($urandom);
        i = 0;
        do
            @(negedge core_clk);
        while (req_ready !== 1'b1 && ++i < 60);
        @(posedge core_clk);
        req_valid <= 1'b0;
        for (i = (i >= 60) ? 500 : 0; i < 500; i++)
        begin
            @(negedge core_clk);
            if (rsp_valid === 1'b1)
            begin
                `CHK({rsp_data, rsp_par}, {ea ^ 32'h5a5a_5a5a, ea[3:0] ^ ea[11:8]})
                `CHK({rsp_cache_fill, rsp_par_en}, {exp_breq, par_on})
                ea = ea + (byt ? 32'd1 : 32'd4);
                k++;
            end
            exc |= (bus_error_exc === 1'b1);
            if (rsp_done === 1'b1)
                break;
        end
        if (i >= 500)
        begin
            err_total++;
            finish_test();
        end
        `CHK(k, e ? 0 : byt ? 4 : exp_breq ? int'(n) : int'(exp_rnw))
        `CHK(exc, e)
        if (exp_rnw && !e)
            `CHK(addr_out_bus, cur_inst_addr)
        else if (!e)
            `CHK({wr_data, wr_par, wr_be}, {req_wdata, req_wpar, req_byte_en})
        `CHK({addr_valid_n, read_strobe_n, byte_write_n, data_out_bus, data_parity_out}, {6'h3f, 32'h0000_0000, 4'h0})
        `CHK({xact_start_n, block_req_out}, 2'h2)
        err_arm <= 1'b0;
    endtask
    // Main sequence: reset, corner cases, then random traffic
    initial
    begin
        int t;
        int r;
        logic [31:0] a;
        void'($urandom(32'h822c_cf2b));
        rst_n = 1'b0;
        req_valid = 1'b0;
        req_op = EMBS_OP_READ;
        req_addr = 32'h0000_0000;
        req_block_words = 5'h02;
        req_wdata = 32'h0000_0000;
        req_wpar = 4'h0;
        req_byte_en = 4'h1;
        cur_inst_addr = 32'h0000_0000;
        {lat, slow, byte_mode, par_on, err_arm} = 8'h00;
        err_total = 0;
        n_tests = 0;
        repeat (6) @(posedge core_clk);
        rst_n <= 1'b1;
        @(negedge core_clk);
        `CHK({xact_start_n, addr_valid_n, read_strobe_n, byte_write_n, block_req_out}, 8'hfe)
        op_run(EMBS_OP_BLOCK, 32'h0000_1234, 5'h10, 4'h3, 1'b1, 1'b0, 1'b0);
        op_run(EMBS_OP_BLOCK, 32'h0000_0a3c, 5'h02, 4'h4, 1'b0, 1'b0, 1'b0);
        op_run(EMBS_OP_BLOCK, 32'h0000_5670, 5'h08, 4'h3, 1'b0, 1'b0, 1'b1);
        op_run(EMBS_OP_READ, 32'h0000_2a04, 5'h02, 4'h0, 1'b0, 1'b0, 1'b0);
        op_run(EMBS_OP_READ, 32'h0000_0103, 5'h02, 4'h2, 1'b1, 1'b1, 1'b0);
        op_run(EMBS_OP_READ, 32'h0000_0201, 5'h02, 4'h2, 1'b0, 1'b1, 1'b1);
        op_run(EMBS_OP_WRITE, 32'h0000_0300, 5'h02, 4'h0, 1'b0, 1'b0, 1'b0);
        op_run(EMBS_OP_WRITE, 32'h0000_0400, 5'h02, 4'h2, 1'b0, 1'b0, 1'b1);
        for (t = 0; t < 24; t++)
        begin
            r = $urandom_range(3, 0);
            a = $urandom;
            op_run(ops[r], r == 3 ? a : a & 32'hffff_fffc, 5'(2 << $urandom_range(3, 0)),
                4'($urandom_range(6, 3)), 1'($urandom), r == 3, $urandom_range(7, 0) == 0);
        end
        finish_test();
    end
endmodule
`default_nettype wire
